// file: hdl/swpcf_loader.sv
`timescale 1ns/1ns
module swpcf_loader (
  input wire logic clk_sys, // 20 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic pl_valid, // preload word strobe from the store reader
  input wire logic [swpcf_pkg::PL_AW-1:0] pl_addr, // preload word address
  input wire logic [swpcf_pkg::PL_DW-1:0] pl_data, // preload word
  input wire logic pl_done, // store reader finished the sequence
  input wire logic [swpcf_pkg::AVS_AW-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  output logic cfg_ready, // loading finished, config open
  output swpcf_pkg::swpcf_fields_all_t port_fields // per-port field images
);

  ////////////////////////////////////////////////////////////////////////////
  // loader state

  logic ready_r;
  logic ready_nxt;
  logic pl_en_r;
  logic [swpcf_pkg::CNT_W-1:0] acc_cnt_r;
  logic [swpcf_pkg::CNT_W-1:0] ign_cnt_r;
  logic [swpcf_pkg::PL_AW-1:0] last_addr_r;
  logic [swpcf_pkg::PL_DW-1:0] last_data_r;
  logic [swpcf_pkg::NPORT-1:0] claim;
  logic any_claim;
  logic pl_take;
  logic pl_use;
  logic rearm;

  // words arriving once the image is frozen are dropped, so software
  // never sees a field change under it
  assign pl_take = pl_valid && pl_en_r && !ready_r;
  assign any_claim = |claim;
  assign pl_use = pl_take && any_claim;

  genvar gp;
  generate
    for (gp = 0; gp < swpcf_pkg::NPORT; gp++) begin : g_port
      swpcf_port #(
        .PORT_ID(2'(gp))
      ) u_port (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_stb(pl_take),
        .wr_addr(pl_addr),
        .wr_data(pl_data),
        .claim(claim[gp]),
        .fields_r(port_fields[gp])
      );
    end
  endgenerate

  always_comb begin
    ready_nxt = ready_r;
    // the set outranks a rearm landing in the same cycle
    if (pl_done) begin
      ready_nxt = 1'b1;
    end else if (rearm) begin
      ready_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= ready_nxt;
    end
  end

  assign cfg_ready = ready_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_cnt_r <= 8'h00;
    end else if (rearm) begin
      acc_cnt_r <= 8'h00;
    end else if (pl_use && acc_cnt_r != 8'hFF) begin
      acc_cnt_r <= acc_cnt_r + 8'h01;
    end
  end

  // counts words seen but not applied: frozen, disabled, or no destination
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ign_cnt_r <= 8'h00;
    end else if (rearm) begin
      ign_cnt_r <= 8'h00;
    end else if (pl_valid && !pl_use && ign_cnt_r != 8'hFF) begin
      ign_cnt_r <= ign_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last_addr_r <= 8'h00;
      last_data_r <= 16'h0000;
    end else if (pl_use) begin
      last_addr_r <= pl_addr;
      last_data_r <= pl_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration word view

  function automatic logic [31:0] cfg_word(
    input swpcf_pkg::swpcf_fields_t f,
    input logic [swpcf_pkg::CFG_OW-1:0] off
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (off)
      swpcf_pkg::CFG_PMCAP: begin
        w[swpcf_pkg::CF_DSI] = f.dsi_required;
        w[swpcf_pkg::CF_AUX +: 3] = f.aux_current;
        w[swpcf_pkg::CF_D1] = f.d1_support;
        w[swpcf_pkg::CF_D2] = f.d2_support;
        w[swpcf_pkg::CF_PME +: 2] = f.pme_d2d1;
      end
      swpcf_pkg::CFG_PMCSR: begin
        w[swpcf_pkg::CF_NSR] = f.no_soft_reset;
        w[swpcf_pkg::CF_PMDATA +: 8] = f.pm_data;
      end
      swpcf_pkg::CFG_PCIECAP: begin
        w[swpcf_pkg::CF_SLOT] = f.slot_impl;
      end
      swpcf_pkg::CFG_LINKCAP: begin
        w[swpcf_pkg::CF_PNUM +: 3] = f.port_num;
      end
      swpcf_pkg::CFG_LINKSTAT: begin
        w[swpcf_pkg::CF_SCLK] = f.slot_clock;
      end
      swpcf_pkg::CFG_VCCAP: begin
        w[swpcf_pkg::CF_LPCG] = f.low_priority_channel_group;
      end
      swpcf_pkg::CFG_VCMAP: begin
        w[swpcf_pkg::CF_TCMAP +: 7] = f.tc_vc0_map;
      end
      swpcf_pkg::CFG_BUDGET: begin
        w[swpcf_pkg::CF_BPWR +: 8] = f.base_power;
        w[swpcf_pkg::CF_SCALE +: 2] = f.data_scale;
        w[swpcf_pkg::CF_PMST +: 2] = f.pm_state;
      end
      swpcf_pkg::CFG_BUDSYS: begin
        w[swpcf_pkg::CF_SYSAL] = f.sys_alloc;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction : cfg_word

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave

  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  logic req;
  logic is_ctl;
  logic gate;
  logic accept;
  logic wr_fire;
  logic [1:0] cfg_port;
  logic [swpcf_pkg::CFG_OW-1:0] cfg_off;

  assign req = avs_read || avs_write;
  assign is_ctl = avs_address[swpcf_pkg::AVS_SEL];
  assign cfg_port = avs_address[11:10];
  assign cfg_off = avs_address[swpcf_pkg::CFG_OW-1:0];
  // config window stalls until the image is complete; loader regs never do
  assign gate = is_ctl || ready_r;
  assign accept = req && wait_r && gate;
  assign wr_fire = avs_write && !wait_r;
  assign rearm = wr_fire && avs_address == swpcf_pkg::REG_CTRL && avs_byteenable[0]
    && avs_writedata[swpcf_pkg::CTL_REARM];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (!is_ctl) begin
      rd_mux = cfg_word(port_fields[cfg_port], cfg_off);
    end else if (avs_address == swpcf_pkg::REG_CTRL) begin
      rd_mux[swpcf_pkg::CTL_EN] = pl_en_r;
    end else if (avs_address == swpcf_pkg::REG_STATUS) begin
      rd_mux = {8'h00, ign_cnt_r, acc_cnt_r, 7'h00, ready_r};
    end else if (avs_address == swpcf_pkg::REG_LAST) begin
      rd_mux = {8'h00, last_addr_r, last_data_r};
    end
  end

  // one stall cycle per request once gate is high; the answer edge is the one after acceptance
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_r <= 1'b1;
    end else if (accept) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (accept && avs_read) begin
      rdata_r <= rd_mux;
    end
  end

  // config words are read-only: writes there are answered and dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pl_en_r <= swpcf_pkg::CTL_EN_RST;
    end else if (wr_fire && avs_address == swpcf_pkg::REG_CTRL && avs_byteenable[0]) begin
      pl_en_r <= avs_writedata[swpcf_pkg::CTL_EN];
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

endmodule : swpcf_loader

// file: include/swpcf_pkg.sv
package swpcf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NPORT = 4;
  localparam int PL_AW = 8;
  localparam int PL_DW = 16;
  localparam int AVS_AW = 13;
  localparam int CFG_OW = 10;
  localparam int CNT_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // preload word addresses, port p sits at base + 2*p
  localparam logic [PL_AW-1:0] PL_PMCAP_BASE = 8'h50;
  localparam logic [PL_AW-1:0] PL_PMDATA_BASE = 8'h51;
  localparam logic [PL_AW-1:0] PL_MISC_BASE = 8'h60;
  localparam logic [PL_AW-1:0] PL_BUDGET_BASE = 8'h70;

  // field positions inside preload words
  localparam int PL_NSR = 0;
  localparam int PL_AUX = 1;
  localparam int PL_D1 = 4;
  localparam int PL_D2 = 5;
  localparam int PL_PME = 6;
  localparam int PL_PMDATA = 8;
  localparam int PL_SLOT = 0;
  localparam int PL_SCLK = 1;
  localparam int PL_DSI = 2;
  localparam int PL_LPCG = 3;
  localparam int PL_PNUM = 4;
  localparam int PL_TCMAP = 9;
  localparam int PL_BPWR = 0;
  localparam int PL_SCALE = 8;
  localparam int PL_PMST = 10;
  localparam int PL_SYSAL = 15;

  ////////////////////////////////////////////////////////////////////////////
  // configuration offsets of each port
  localparam logic [CFG_OW-1:0] CFG_PMCAP = 10'h040;
  localparam logic [CFG_OW-1:0] CFG_PMCSR = 10'h044;
  localparam logic [CFG_OW-1:0] CFG_PCIECAP = 10'h0C0;
  localparam logic [CFG_OW-1:0] CFG_LINKCAP = 10'h0CC;
  localparam logic [CFG_OW-1:0] CFG_LINKSTAT = 10'h0D0;
  localparam logic [CFG_OW-1:0] CFG_VCCAP = 10'h144;
  localparam logic [CFG_OW-1:0] CFG_VCMAP = 10'h154;
  localparam logic [CFG_OW-1:0] CFG_BUDGET = 10'h214;
  localparam logic [CFG_OW-1:0] CFG_BUDSYS = 10'h218;

  // field positions inside configuration words
  localparam int CF_DSI = 21;
  localparam int CF_AUX = 22;
  localparam int CF_D1 = 25;
  localparam int CF_D2 = 26;
  localparam int CF_PME = 28;
  localparam int CF_NSR = 3;
  localparam int CF_PMDATA = 24;
  localparam int CF_SLOT = 24;
  localparam int CF_PNUM = 24;
  localparam int CF_SCLK = 28;
  localparam int CF_LPCG = 4;
  localparam int CF_TCMAP = 1;
  localparam int CF_BPWR = 0;
  localparam int CF_SCALE = 8;
  localparam int CF_PMST = 13;
  localparam int CF_SYSAL = 0;

  ////////////////////////////////////////////////////////////////////////////
  // loader control window (byte addresses)
  localparam int AVS_SEL = 12;
  localparam logic [AVS_AW-1:0] REG_CTRL = 13'h1000;
  localparam logic [AVS_AW-1:0] REG_STATUS = 13'h1004;
  localparam logic [AVS_AW-1:0] REG_LAST = 13'h1008;
  localparam int CTL_EN = 0;
  localparam int CTL_REARM = 1;
  localparam logic CTL_EN_RST = 1'b1;

  typedef struct packed {
    logic no_soft_reset;
    logic [2:0] aux_current;
    logic d1_support;
    logic d2_support;
    logic [1:0] pme_d2d1;
    logic [7:0] pm_data;
    logic slot_clock;
    logic dsi_required;
    logic low_priority_channel_group;
    logic [2:0] port_num;
    logic [6:0] tc_vc0_map;
    logic slot_impl;
    logic [7:0] base_power;
    logic [1:0] data_scale;
    logic [1:0] pm_state;
    logic sys_alloc;
  } swpcf_fields_t;

  typedef swpcf_fields_t [NPORT-1:0] swpcf_fields_all_t;

  // hardware defaults that stand until a preload word replaces them
  localparam swpcf_fields_t FIELDS_RST = '{
    no_soft_reset: 1'b0, aux_current: 3'h0, d1_support: 1'b0, d2_support: 1'b0,
    pme_d2d1: 2'h0, pm_data: 8'h00, slot_clock: 1'b0, dsi_required: 1'b0,
    low_priority_channel_group: 1'b0, port_num: 3'h0, tc_vc0_map: 7'h00,
    slot_impl: 1'b0, base_power: 8'h00, data_scale: 2'h0, pm_state: 2'h0,
    sys_alloc: 1'b0};

endpackage : swpcf_pkg

// file: hdl/swpcf_port.sv
`timescale 1ns/1ns
module swpcf_port #(
  parameter logic [1:0] PORT_ID = 2'h0
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset
  input wire logic wr_stb, // preload word accepted
  input wire logic [swpcf_pkg::PL_AW-1:0] wr_addr, // preload word address
  input wire logic [swpcf_pkg::PL_DW-1:0] wr_data, // preload word
  output logic claim, // address belongs to this port
  output swpcf_pkg::swpcf_fields_t fields_r // loaded field image
);

  logic [swpcf_pkg::PL_AW-1:0] step;
  logic hit_pmcap;
  logic hit_pmdata;
  logic hit_misc;
  logic hit_budget;

  assign step = {5'h00, PORT_ID, 1'b0};
  assign hit_pmcap = wr_addr == swpcf_pkg::PL_PMCAP_BASE + step;
  assign hit_pmdata = wr_addr == swpcf_pkg::PL_PMDATA_BASE + step;
  assign hit_misc = wr_addr == swpcf_pkg::PL_MISC_BASE + step;
  assign hit_budget = wr_addr == swpcf_pkg::PL_BUDGET_BASE + step;
  assign claim = hit_pmcap | hit_pmdata | hit_misc | hit_budget;

  ////////////////////////////////////////////////////////////////////////////
  // bits with no destination are simply never copied
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fields_r <= swpcf_pkg::FIELDS_RST;
    end else if (wr_stb && hit_pmcap) begin
      fields_r.no_soft_reset <= wr_data[swpcf_pkg::PL_NSR];
      fields_r.aux_current <= wr_data[swpcf_pkg::PL_AUX +: 3];
      fields_r.d1_support <= wr_data[swpcf_pkg::PL_D1];
      fields_r.d2_support <= wr_data[swpcf_pkg::PL_D2];
      fields_r.pme_d2d1 <= wr_data[swpcf_pkg::PL_PME +: 2];
    end else if (wr_stb && hit_pmdata) begin
      fields_r.pm_data <= wr_data[swpcf_pkg::PL_PMDATA +: 8];
    end else if (wr_stb && hit_misc) begin
      if (PORT_ID != 2'h0) begin
        fields_r.slot_impl <= wr_data[swpcf_pkg::PL_SLOT];
      end
      fields_r.slot_clock <= wr_data[swpcf_pkg::PL_SCLK];
      fields_r.dsi_required <= wr_data[swpcf_pkg::PL_DSI];
      fields_r.low_priority_channel_group <= wr_data[swpcf_pkg::PL_LPCG];
      fields_r.port_num <= wr_data[swpcf_pkg::PL_PNUM +: 3];
      fields_r.tc_vc0_map <= wr_data[swpcf_pkg::PL_TCMAP +: 7];
    end else if (wr_stb && hit_budget) begin
      fields_r.base_power <= wr_data[swpcf_pkg::PL_BPWR +: 8];
      fields_r.data_scale <= wr_data[swpcf_pkg::PL_SCALE +: 2];
      fields_r.pm_state <= wr_data[swpcf_pkg::PL_PMST +: 2];
      fields_r.sys_alloc <= wr_data[swpcf_pkg::PL_SYSAL];
    end
  end

endmodule : swpcf_port

// file: tb/swpcf_loader_asserts.sv
`timescale 1ns/1ns
module swpcf_loader_asserts (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset
  input wire logic pl_valid, // word strobe
  input wire logic [swpcf_pkg::PL_AW-1:0] pl_addr, // word address
  input wire logic [swpcf_pkg::PL_DW-1:0] pl_data, // word
  input wire logic pl_done, // sequence finished
  input wire logic [swpcf_pkg::AVS_AW-1:0] avs_address, // byte address
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  input wire logic avs_waitrequest, // stall
  input wire logic cfg_ready, // config open
  input wire swpcf_pkg::swpcf_fields_all_t port_fields // field images
);
  logic en_r;
  logic take;
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the preload enable, so words refused by en=0 are not faults
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_r <= swpcf_pkg::CTL_EN_RST;
    end else if (avs_write && !avs_waitrequest && avs_address == swpcf_pkg::REG_CTRL && avs_byteenable[0]) begin
      en_r <= avs_writedata[swpcf_pkg::CTL_EN];
    end
  end
  assign take = pl_valid && en_r && !cfg_ready;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  pmcap_load_a: assert property (take && pl_addr == 8'h54 |=>
    {port_fields[2].pme_d2d1, port_fields[2].d2_support, port_fields[2].d1_support,
     port_fields[2].aux_current, port_fields[2].no_soft_reset} == $past(pl_data[7:0]))
    else $error("pm capability word not loaded");
  pmdata_load_a: assert property (take && pl_addr == 8'h57 |=> port_fields[3].pm_data == $past(pl_data[15:8]))
    else $error("pm data byte not loaded");
  misc_load_a: assert property (take && pl_addr == 8'h60 |=>
    {port_fields[0].tc_vc0_map, port_fields[0].port_num, port_fields[0].low_priority_channel_group,
     port_fields[0].dsi_required, port_fields[0].slot_clock} == {$past(pl_data[15:9]), $past(pl_data[6:1])}
    && $stable(port_fields[0].slot_impl))
    else $error("misc word of port 0 not loaded");
  slot_load_a: assert property (take && pl_addr == 8'h66 |=> port_fields[3].slot_impl == $past(pl_data[0]))
    else $error("slot implemented not loaded");
  budget_load_a: assert property (take && pl_addr == 8'h72 |=>
    {port_fields[1].sys_alloc, port_fields[1].pm_state, port_fields[1].data_scale, port_fields[1].base_power}
    == {$past(pl_data[15]), $past(pl_data[11:0])})
    else $error("budget word not loaded");
  unmapped_word_a: assert property (take && pl_addr == 8'h58 |=> $stable(port_fields))
    else $error("unmapped word changed fields");
  late_word_a: assert property (pl_valid && cfg_ready |=> $stable(port_fields))
    else $error("word after loading changed fields");
  ready_open_a: assert property (pl_done |=> cfg_ready)
    else $error("loading end not seen");
  cfg_gate_a: assert property (!avs_waitrequest && !avs_address[12] |-> cfg_ready)
    else $error("config answered before loading ended");
  reset_image_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    rst |=> port_fields == {swpcf_pkg::NPORT{swpcf_pkg::FIELDS_RST}} && !cfg_ready)
    else $error("reset image wrong");
endmodule : swpcf_loader_asserts

bind swpcf_loader swpcf_loader_asserts asserts_u (.clk_sys(clk_sys), .rst(rst), .pl_valid(pl_valid),
  .pl_addr(pl_addr), .pl_data(pl_data), .pl_done(pl_done), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .cfg_ready(cfg_ready), .port_fields(port_fields));

// file: tb/swpcf_store_model.sv
`timescale 1ns/1ns
module swpcf_store_model (
  input wire logic clk_sys, // system clock
  output logic pl_valid, // word strobe
  output logic [swpcf_pkg::PL_AW-1:0] pl_addr, // word address
  output logic [swpcf_pkg::PL_DW-1:0] pl_data, // word
  output logic pl_done // sequence finished
);
  initial begin
    pl_valid = 1'b0;
    pl_addr = 8'h00;
    pl_data = 16'h0000;
    pl_done = 1'b0;
  end
  // caller sits just after a rising edge; the word is taken at the next one
  task automatic send(input logic [7:0] a, input logic [15:0] d);
    pl_valid <= 1'b1;
    pl_addr <= a;
    pl_data <= d;
    @(posedge clk_sys);
  endtask : send
  // a released store bus shows the inverse, never a stale word
  task automatic idle(input int n);
    pl_valid <= 1'b0;
    pl_addr <= ~pl_addr;
    pl_data <= ~pl_data;
    repeat (n) @(posedge clk_sys);
  endtask : idle
  task automatic end_seq();
    pl_done <= 1'b1;
    @(posedge clk_sys);
    pl_done <= 1'b0;
  endtask : end_seq
endmodule : swpcf_store_model

// file: tb/switch_port_cfg_preload_map_tb.sv
`timescale 1ns/1ns
module switch_port_cfg_preload_map_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic pl_valid;
  logic [7:0] pl_addr;
  logic [15:0] pl_data;
  logic pl_done;
  logic [12:0] avs_address = 13'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cfg_ready;
  swpcf_pkg::swpcf_fields_all_t fields;
  swpcf_pkg::swpcf_fields_all_t exp;
  int bad_count = 0;
  int checks = 0;
  logic [7:0] wl[$];
  logic [9:0] offs[10] = '{10'h040, 10'h044, 10'h0C0, 10'h0CC, 10'h0D0, 10'h144, 10'h154, 10'h214, 10'h218, 10'h048};
  logic [31:0] r;
  logic [15:0] d;

  always #25 clk_sys = ~clk_sys;

  swpcf_store_model store_u (.clk_sys(clk_sys), .pl_valid(pl_valid), .pl_addr(pl_addr), .pl_data(pl_data),
    .pl_done(pl_done));
  swpcf_loader dut_u (.clk_sys(clk_sys), .rst(rst), .pl_valid(pl_valid), .pl_addr(pl_addr), .pl_data(pl_data),
    .pl_done(pl_done), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cfg_ready(cfg_ready), .port_fields(fields));

  ////////////////////////////////////////////////////////////////////////////
  function automatic swpcf_pkg::swpcf_fields_all_t apply(input swpcf_pkg::swpcf_fields_all_t e,
    input logic [7:0] a, input logic [15:0] w);
    logic [1:0] p;
    p = a[2:1];
    if (a[7:3] == 5'h0A && !a[0]) begin
      e[p].no_soft_reset = w[0];
      e[p].aux_current = w[3:1];
      e[p].d1_support = w[4];
      e[p].d2_support = w[5];
      e[p].pme_d2d1 = w[7:6];
    end else if (a[7:3] == 5'h0A) begin
      e[p].pm_data = w[15:8];
    end else if (a[7:3] == 5'h0C && !a[0]) begin
      // port 0 has no slot
      if (p != 2'h0) e[p].slot_impl = w[0];
      e[p].slot_clock = w[1];
      e[p].dsi_required = w[2];
      e[p].low_priority_channel_group = w[3];
      e[p].port_num = w[6:4];
      e[p].tc_vc0_map = w[15:9];
    end else if (a[7:3] == 5'h0E && !a[0]) begin
      e[p].base_power = w[7:0];
      e[p].data_scale = w[9:8];
      e[p].pm_state = w[11:10];
      e[p].sys_alloc = w[15];
    end
    return e;
  endfunction : apply

  function automatic logic [31:0] cfgw(input swpcf_pkg::swpcf_fields_t f, input logic [9:0] o);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (o)
      10'h040: w = {2'h0, f.pme_d2d1, 1'b0, f.d2_support, f.d1_support, f.aux_current, f.dsi_required, 21'h0};
      10'h044: w = {f.pm_data, 20'h0, f.no_soft_reset, 3'h0};
      10'h0C0: w[24] = f.slot_impl;
      10'h0CC: w[26:24] = f.port_num;
      10'h0D0: w[28] = f.slot_clock;
      10'h144: w[4] = f.low_priority_channel_group;
      10'h154: w[7:1] = f.tc_vc0_map;
      10'h214: w = {17'h0, f.pm_state, 3'h0, f.data_scale, f.base_power};
      10'h218: w[0] = f.sys_alloc;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : cfgw

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk

  task automatic av(input logic we, input logic [12:0] a, input logic [31:0] wd, output logic [31:0] rd);
    avs_address <= a;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= wd;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : av

  task automatic summarize();
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end

  initial begin
    exp = {swpcf_pkg::NPORT{swpcf_pkg::FIELDS_RST}};
    void'($urandom(32'h122f1528));
    for (int i = 0; i < 8; i++) wl.push_back(8'h50 + 8'(i));
    for (int p = 0; p < 4; p++) wl.push_back(8'h60 + 8'(2 * p));
    for (int p = 0; p < 4; p++) wl.push_back(8'h70 + 8'(2 * p));
    wl.push_back(8'h58);
    wl.push_back(8'h61);
    repeat (20) @(posedge clk_sys);
    chk(fields === exp && cfg_ready === 1'b0, "reset image");
    rst <= 1'b0;
    // pass 0 all ones, pass 1 random with gaps, pass 2 random back to back
    for (int k = 0; k < 3; k++) begin
      foreach (wl[i]) begin
        d = (k == 0) ? 16'hFFFF : 16'($urandom);
        store_u.send(wl[i], d);
        exp = apply(exp, wl[i], d);
        if (k != 2) store_u.idle($urandom_range(1, 3));
        if (k != 2) chk(fields === exp, "field image");
      end
      if (k == 2) store_u.idle(1);
      chk(fields === exp, "image after pass");
    end
    store_u.end_seq();
    store_u.send(8'h54, 16'($urandom));
    store_u.idle(2);
    chk(fields === exp && cfg_ready === 1'b1, "word after loading end");
    for (int p = 0; p < 4; p++) begin
      for (int o = 0; o < 10; o++) begin
        av(1'b0, {1'b0, 2'(p), offs[o]}, 32'h0000_0000, r);
        chk(r === cfgw(exp[p], offs[o]), "config read");
      end
    end
    av(1'b1, {1'b0, 2'h1, 10'h040}, 32'hFFFF_FFFF, r);
    av(1'b0, {1'b0, 2'h1, 10'h040}, 32'h0000_0000, r);
    chk(r === cfgw(exp[1], 10'h040), "read-only config written");
    av(1'b0, swpcf_pkg::REG_STATUS, 32'h0000_0000, r);
    // 3 passes of 16 mapped words applied; 6 unmapped plus 1 late word ignored
    chk(r === 32'h0007_3001, "status ready");
    av(1'b0, 13'h100C, 32'h0000_0000, r);
    chk(r === 32'h0000_0000, "unmapped loader read");
    // rearm with preload disabled: counters clear, the refused word is only counted
    av(1'b1, swpcf_pkg::REG_CTRL, 32'h0000_0002, r);
    av(1'b0, swpcf_pkg::REG_STATUS, 32'h0000_0000, r);
    chk(r === 32'h0000_0000, "status after rearm");
    store_u.send(8'h54, 16'hFFFF);
    store_u.idle(1);
    chk(fields === exp, "word while disabled");
    av(1'b1, swpcf_pkg::REG_CTRL, 32'h0000_0001, r);
    av(1'b0, swpcf_pkg::REG_CTRL, 32'h0000_0000, r);
    chk(r === 32'h0000_0001, "enable readback");
    d = 16'($urandom);
    store_u.send(8'h56, d);
    exp = apply(exp, 8'h56, d);
    store_u.idle(1);
    chk(fields === exp, "word after rearm");
    av(1'b0, swpcf_pkg::REG_STATUS, 32'h0000_0000, r);
    chk(r === 32'h0001_0100, "status counts");
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    exp = {swpcf_pkg::NPORT{swpcf_pkg::FIELDS_RST}};
    chk(fields === exp && cfg_ready === 1'b0, "image after second reset");
    summarize();
  end
endmodule : switch_port_cfg_preload_map_tb
